// ---- logic/machine_check_bank_logger.sv ----
`timescale 1ns/1ps
// one error-reporting bank with overwrite priority
module machine_check_bank_logger #(
	parameter bit MODEL_CODE_EN = 1'b1
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	input  wire logic        i_err_valid,
	input  wire logic [2:0]  i_err_class,
	input  wire logic [3:0]  i_err_src,
	input  wire logic [9:0]  i_int_detail,
	input  wire logic [15:0] i_compound_code,
	input  wire logic [15:0] i_model_code,
	input  wire logic        i_as_exception,
	input  wire logic        i_status_clear,
	input  wire logic        i_recovery_support_cap,
	input  wire logic        i_control_reg_four_trap_en,
	input  wire logic        i_bank_enable,
	output logic             o_entry_live_flag,
	output logic             o_uncorrected_flag,
	output logic             o_context_corrupt_flag,
	output logic             o_overflow,
	output logic             o_log_gate,
	output logic             o_trap_flag,
	output logic             o_action_required,
	output logic [15:0]      o_arch_code,
	output logic [15:0]      o_model_code,
	output logic [2:0]       o_logged_class,
	output logic [31:0]      o_global_capability_register,
	output logic [31:0]      o_feature_result_reg,
	output logic             o_trap_raise,
	output logic [7:0]       o_trap_vector,
	output logic             o_notice_pulse
);
	typedef struct packed {
		logic        live;
		logic        uc;
		logic        context_corrupt_flag;
		logic        over;
		logic        gate;
		logic        trap;
		logic        act;
		logic [15:0] code;
		logic [15:0] mcode;
		logic [2:0]  cls;
		logic [31:0] cap;
		logic [31:0] feat;
		logic        raise;
		logic [7:0]  vec;
		logic        notice;
	} state_s;

	state_s st_reg;
	state_s st_next;
	logic [15:0] new_code;

	mc_code_encode u_enc (
		.i_src        (i_err_src),
		.i_int_detail (i_int_detail),
		.i_compound   (i_compound_code),
		.o_code       (new_code)
	);

	// true for the three recoverable uncorrected classes
	function automatic logic is_recov(input logic [2:0] c);
		is_recov = (c == mc_bank_pkg::CLS_LATENT) || (c == mc_bank_pkg::CLS_OPTIONAL) ||
			(c == mc_bank_pkg::CLS_MANDATORY);
	endfunction

	logic [2:0] cls_in;

	// without the capability, recoverable classes degrade to corrupt uncorrected
	always_comb begin
		cls_in = i_err_class;
		if (is_recov(i_err_class) && !i_recovery_support_cap) begin
			cls_in = mc_bank_pkg::CLS_CORRUPT; // RQ9
		end
	end

	// overwrite decision made in the capture cycle against the logged class
	always_comb begin
		logic take;
		logic nrec;
		logic old_rec;
		take = 1'b0;
		nrec = is_recov(cls_in);
		old_rec = st_reg.live && st_reg.uc && !st_reg.context_corrupt_flag;
		st_next = st_reg;
		st_next.raise = 1'b0;
		st_next.notice = 1'b0;
		st_next.cap = mc_bank_pkg::CAP_RESET;
		st_next.cap[mc_bank_pkg::CAP_RECOVERY_BIT] = i_recovery_support_cap; // RQ9
		st_next.feat = mc_bank_pkg::FEAT_RESET; // RQ11
		st_next.vec = mc_bank_pkg::TRAP_VECTOR; // RQ21
		if (i_status_clear) begin
			// software clear of the whole status; a same-cycle error still lands below
			// RQ12
			st_next.live = 1'b0;
			st_next.uc = 1'b0;
			st_next.context_corrupt_flag = 1'b0;
			st_next.over = 1'b0;
			st_next.gate = 1'b0;
			st_next.trap = 1'b0;
			st_next.act = 1'b0;
			st_next.code = mc_bank_pkg::CODE_NONE; // RQ17
			st_next.mcode = 16'h0000;
			st_next.cls = mc_bank_pkg::CLS_CORRECTED;
			old_rec = 1'b0;
		end
		if (i_err_valid && i_bank_enable) begin
			if (!st_next.live) begin
				take = 1'b1; // RQ13
			end else begin
				st_next.over = 1'b1; // RQ5
				if (st_reg.cls == mc_bank_pkg::CLS_CORRECTED) begin
					take = nrec || (cls_in == mc_bank_pkg::CLS_CORRUPT); // RQ1 RQ25
				end else if (old_rec) begin
					// RQ3 RQ4: only context-corrupt may displace
					take = (cls_in == mc_bank_pkg::CLS_CORRUPT); // RQ2
				end
			end
			if (take) begin
				st_next.live = 1'b1; // RQ13
				st_next.code = new_code; // RQ15
				st_next.mcode = MODEL_CODE_EN ? i_model_code : 16'h0000; // RQ14
				st_next.cls = cls_in;
				st_next.uc = (cls_in != mc_bank_pkg::CLS_CORRECTED);
				st_next.context_corrupt_flag = (cls_in == mc_bank_pkg::CLS_CORRUPT);
			end
			// sticky merge: flags only ever set by hardware
			case (cls_in)
				mc_bank_pkg::CLS_MANDATORY: begin
					st_next.gate = 1'b1; // RQ23
					st_next.trap = 1'b1; // RQ7
					st_next.act = 1'b1; // RQ7
				end
				mc_bank_pkg::CLS_OPTIONAL: begin
					if (i_as_exception) begin
						st_next.gate = 1'b1; // RQ10
						st_next.trap = 1'b1; // RQ7
					end
				end
				mc_bank_pkg::CLS_CORRUPT: begin
					st_next.gate = 1'b1;
				end
				default: begin
					// latent and corrected leave trap/action untouched
					st_next.gate = st_next.gate; // RQ24 RQ6
				end
			endcase
			// delivery: exception only when enabled by control bit 6
			if ((cls_in == mc_bank_pkg::CLS_MANDATORY) || (cls_in == mc_bank_pkg::CLS_CORRUPT) ||
				((cls_in == mc_bank_pkg::CLS_OPTIONAL) && i_as_exception)) begin
				st_next.raise = i_control_reg_four_trap_en; // RQ21
			end else begin
				st_next.notice = 1'b1; // RQ24 RQ10
			end
		end
	end

	// single state register
	always_ff @(posedge i_core_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from the state flops
	assign o_entry_live_flag = st_reg.live;
	assign o_uncorrected_flag = st_reg.uc;
	assign o_context_corrupt_flag = st_reg.context_corrupt_flag;
	assign o_overflow = st_reg.over;
	assign o_log_gate = st_reg.gate;
	assign o_trap_flag = st_reg.trap;
	assign o_action_required = st_reg.act;
	assign o_arch_code = st_reg.code;
	assign o_model_code = st_reg.mcode;
	assign o_logged_class = st_reg.cls;
	assign o_global_capability_register = st_reg.cap;
	assign o_feature_result_reg = st_reg.feat;
	assign o_trap_raise = st_reg.raise;
	assign o_trap_vector = st_reg.vec;
	assign o_notice_pulse = st_reg.notice;
endmodule

// ---- logic/mc_bank_pkg.sv ----
// Functional notes
// (RQ1) recoverable uncorrected replaces logged corrected error
// (RQ2) context-corrupt uncorrected replaces recoverable; flags undefined
// (RQ3) recoverable never replaces earlier recoverable entry
// (RQ4) corrected never replaces logged recoverable entry
// (RQ5) any second error on live entry sets overflow
// (RQ6) trap and action-required flags sticky against hardware
// (RQ7) merged trap/action flags from both recoverable errors
// (RQ8) software resets only if action or corrupt set
// (RQ9) recoverable classes reported only with capability bit 24
// (RQ10) exception delivery sets log-gate and trap; notice leaves trap clear
// (RQ11) feature result bit 14 and bit 7 report support
// (RQ12) software clears status before trusting it
// (RQ13) detected error writes 16-bit code, sets entry live
// (RQ14) optional 16-bit model-specific code stored alongside
// (RQ15) code field bits 15:0 alone name error type
// (RQ16) code field holds simple or compound family
// (RQ17) empty bank carries all-zero code
// (RQ18) unclassified codes 0001 and internal 0000 01xx pattern
// (RQ19) rom parity, bus reinit, redundancy, internal parity codes
// (RQ20) handler violation, timer and generic io codes
// (RQ21) exception vector 18, enabled by control bit 6
// (RQ22) software enables all bank control bits
// (RQ23) mandatory recovery logged with uc, gate, trap, action
// (RQ24) latent no-action logged uc only, as notice
// (RQ25) overwrite decided against logged class same cycle
package mc_bank_pkg;
	// incoming error classes
	typedef enum logic [2:0] {
		CLS_CORRECTED = 3'h0,
		CLS_LATENT    = 3'h1,
		CLS_OPTIONAL  = 3'h3,
		CLS_MANDATORY = 3'h2,
		CLS_CORRUPT   = 3'h6
	} err_class_e;

	// simple architectural codes
	localparam logic [15:0] CODE_NONE         = 16'h0000;
	localparam logic [15:0] CODE_UNCLASSIFIED = 16'h0001;
	localparam logic [15:0] CODE_UROM_PARITY  = 16'h0002;
	localparam logic [15:0] CODE_BUS_REINIT   = 16'h0003;
	localparam logic [15:0] CODE_REDUNDANCY   = 16'h0004;
	localparam logic [15:0] CODE_INT_PARITY   = 16'h0005;
	localparam logic [15:0] CODE_SMH_VIOLATE  = 16'h0006;
	localparam logic [15:0] CODE_TIMER        = 16'h0400;
	localparam logic [15:0] CODE_GENERIC_IO   = 16'h0E0B;
	localparam logic [15:0] CODE_INT_UNCL_BASE = 16'h0400;

	// simple and compound error sources selected on the input
	typedef enum logic [3:0] {
		SRC_UNCLASSIFIED = 4'h0,
		SRC_UROM_PARITY  = 4'h1,
		SRC_BUS_REINIT   = 4'h2,
		SRC_REDUNDANCY   = 4'h3,
		SRC_INT_PARITY   = 4'h4,
		SRC_SMH_VIOLATE  = 4'h5,
		SRC_TIMER        = 4'h6,
		SRC_GENERIC_IO   = 4'h7,
		SRC_INT_UNCL     = 4'h8,
		SRC_COMPOUND     = 4'h9
	} err_src_e;

	// capability and feature bit positions
	localparam int CAP_RECOVERY_BIT   = 24;
	localparam int FEAT_ARCH_BIT      = 14;
	localparam int FEAT_TRAP_BIT      = 7;
	localparam int CTRL4_TRAP_EN_BIT  = 6;
	localparam logic [7:0] TRAP_VECTOR = 8'h12;
	localparam logic [31:0] CAP_RESET  = 32'h0100_0000;
	localparam logic [31:0] FEAT_RESET = 32'h0000_4080;
endpackage

// ---- logic/mc_code_encode.sv ----
`timescale 1ns/1ps
// maps a source select to the 16-bit architectural code
module mc_code_encode (
	input  wire logic [3:0]  i_src,
	input  wire logic [9:0]  i_int_detail,
	input  wire logic [15:0] i_compound,
	output logic      [15:0] o_code
);
	// combinational encode; registered by the caller
	always_comb begin
		case (i_src)
			mc_bank_pkg::SRC_UNCLASSIFIED: o_code = mc_bank_pkg::CODE_UNCLASSIFIED; // RQ18
			mc_bank_pkg::SRC_UROM_PARITY:  o_code = mc_bank_pkg::CODE_UROM_PARITY; // RQ19
			mc_bank_pkg::SRC_BUS_REINIT:   o_code = mc_bank_pkg::CODE_BUS_REINIT; // RQ19
			mc_bank_pkg::SRC_REDUNDANCY:   o_code = mc_bank_pkg::CODE_REDUNDANCY; // RQ19
			mc_bank_pkg::SRC_INT_PARITY:   o_code = mc_bank_pkg::CODE_INT_PARITY; // RQ19
			mc_bank_pkg::SRC_SMH_VIOLATE:  o_code = mc_bank_pkg::CODE_SMH_VIOLATE; // RQ20
			mc_bank_pkg::SRC_TIMER:        o_code = mc_bank_pkg::CODE_TIMER; // RQ20
			mc_bank_pkg::SRC_GENERIC_IO:   o_code = mc_bank_pkg::CODE_GENERIC_IO; // RQ20
			// zero detail would alias the timer code, so force bit 0
			mc_bank_pkg::SRC_INT_UNCL: begin
				o_code = mc_bank_pkg::CODE_INT_UNCL_BASE | {6'h00, i_int_detail}; // RQ18
				if (i_int_detail == 10'h000) begin
					o_code[0] = 1'b1;
				end
			end
			mc_bank_pkg::SRC_COMPOUND:     o_code = i_compound; // RQ16
			default:                       o_code = mc_bank_pkg::CODE_UNCLASSIFIED;
		endcase
	end
endmodule

// ---- tb/machine_check_bank_logger_monitor.sv ----
`timescale 1ns/1ps
// port-level checker for one bank; recoverable classes assume capability on
module mc_bank_monitor (
	input wire logic        i_core_clk,
	input wire logic        i_nrst,
	input wire logic        i_err_valid,
	input wire logic [2:0]  i_err_class,
	input wire logic        i_status_clear,
	input wire logic        i_recovery_support_cap,
	input wire logic        i_bank_enable,
	input wire logic        o_entry_live_flag,
	input wire logic        o_uncorrected_flag,
	input wire logic        o_context_corrupt_flag,
	input wire logic        o_overflow,
	input wire logic        o_log_gate,
	input wire logic        o_trap_flag,
	input wire logic        o_action_required,
	input wire logic [15:0] o_arch_code,
	input wire logic [31:0] o_feature_result_reg
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	// a clear in the same cycle leaves the bank empty before the error lands
	wire logic take  = i_err_valid && i_bank_enable;
	wire logic fresh = take && (!o_entry_live_flag || i_status_clear);
	wire logic held  = take && o_entry_live_flag && !i_status_clear;
	sequence s_mand; fresh && i_err_class == 3'h2 && i_recovery_support_cap; endsequence
	sequence s_mand_log; o_uncorrected_flag && o_log_gate && o_trap_flag; endsequence
	property p_live; take |=> o_entry_live_flag; endproperty
	property p_over; held |=> o_overflow; endproperty
	property p_trap; o_trap_flag && !i_status_clear |=> o_trap_flag; endproperty
	property p_act; o_action_required && !i_status_clear |=> o_action_required; endproperty
	property p_mand; s_mand |=> s_mand_log and (o_action_required && !o_context_corrupt_flag);
	endproperty
	property p_latent; fresh && i_err_class == 3'h1 && i_recovery_support_cap |=>
		o_uncorrected_flag && !o_context_corrupt_flag && !o_trap_flag && !o_action_required;
	endproperty
	property p_corrupt; take && i_err_class == 3'h6 |=> o_uncorrected_flag && o_context_corrupt_flag;
	endproperty
	// recoverable entry keeps its code against anything but a corrupt error
	// without capability a recoverable class degrades to corrupt and may displace
	property p_keep; held && o_uncorrected_flag && !o_context_corrupt_flag && i_err_class != 3'h6
		&& (i_recovery_support_cap || i_err_class == 3'h0) |=> $stable(o_arch_code);
	endproperty
	property p_empty; !o_entry_live_flag |-> o_arch_code == 16'h0000; endproperty
	property p_feat; $rose(o_entry_live_flag) |-> o_feature_result_reg[14] && o_feature_result_reg[7];
	endproperty
	a_live: assert property (p_live) else $error("taken error not live");
	a_over: assert property (p_over) else $error("overflow not set");
	a_trap: assert property (p_trap) else $error("trap flag lost");
	a_act: assert property (p_act) else $error("action flag lost");
	a_mand: assert property (p_mand) else $error("mandatory flags wrong");
	a_latent: assert property (p_latent) else $error("latent flags wrong");
	a_corrupt: assert property (p_corrupt) else $error("corrupt flags wrong");
	a_keep: assert property (p_keep) else $error("recoverable entry overwritten");
	a_empty: assert property (p_empty) else $error("empty bank code not zero");
	a_feat: assert property (p_feat) else $error("feature bits missing");
endmodule
bind machine_check_bank_logger mc_bank_monitor mc_bank_monitor_i (.i_core_clk, .i_nrst,
	.i_err_valid, .i_err_class, .i_status_clear, .i_recovery_support_cap, .i_bank_enable,
	.o_entry_live_flag, .o_uncorrected_flag, .o_context_corrupt_flag, .o_overflow, .o_log_gate,
	.o_trap_flag, .o_action_required, .o_arch_code, .o_feature_result_reg);

// ---- tb/machine_check_bank_logger_tb_top.sv ----
`timescale 1ns/1ps
module machine_check_bank_logger_tb_top;
	logic        clk = 1'b0, nrst = 1'b0, vld = 1'b0, clr = 1'b0, cap = 1'b1, exc = 1'b0;
	logic        en = 1'b1;
	logic [2:0]  cls = 3'h0;
	logic [3:0]  src = 4'h0;
	logic        live, uc, context_corrupt_flag, over, gate, trap, act;
	logic [15:0] code;
	logic [31:0] cap_reg, feat;
	logic [7:0]  vec;
	logic [15:0] mcode;
	logic [2:0]  lcls;
	logic        raise, notice;
	int          n_errors = 0, checks = 0;
	logic [15:0] exp_code [10] = '{16'h0001, 16'h0002, 16'h0003, 16'h0004, 16'h0005,
		16'h0006, 16'h0400, 16'h0E0B, 16'h0405, 16'h1234};
	// flags packed above the code so one compare covers uc, corrupt, overflow, trap, action and code
	wire logic [31:0] st = {11'h000, uc, context_corrupt_flag, over, trap, act, code};
	always #4 clk = ~clk;
	machine_check_bank_logger machine_check_bank_logger_i (.i_core_clk(clk), .i_nrst(nrst),
		.i_err_valid(vld), .i_err_class(cls), .i_err_src(src), .i_int_detail(10'h005),
		.i_compound_code(16'h1234), .i_model_code(16'hA5A5), .i_as_exception(exc),
		.i_status_clear(clr), .i_recovery_support_cap(cap), .i_control_reg_four_trap_en(1'b1),
		.i_bank_enable(en), .o_entry_live_flag(live), .o_uncorrected_flag(uc),
		.o_context_corrupt_flag(context_corrupt_flag), .o_overflow(over), .o_log_gate(gate), .o_trap_flag(trap),
		.o_action_required(act), .o_arch_code(code), .o_model_code(mcode),
		.o_logged_class(lcls), .o_global_capability_register(cap_reg),
		.o_feature_result_reg(feat), .o_trap_raise(raise),
		.o_trap_vector(vec), .o_notice_pulse(notice));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle error pulse; returns once the entry has settled
	task automatic err(input logic [2:0] c, input logic [3:0] s);
		@(negedge clk) vld = 1'b1;
		cls = c;
		src = s;
		@(negedge clk) vld = 1'b0;
	endtask
	task automatic wipe;
		@(negedge clk) clr = 1'b1;
		@(negedge clk) clr = 1'b0;
	endtask
	task automatic wrap_up;
		$display("checks=%0d n_errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		@(negedge clk) nrst = 1'b1;
		@(negedge clk);
		chk(st, 32'h0);
		chk(feat, 32'h0000_4080);
		chk({23'h0, cap_reg[24], vec}, 32'h0000_0112);
		for (int k = 0; k < 10; k++) begin
			wipe();
			err(3'h0, 4'(k));
			chk(st, {16'h0000, exp_code[k]});
		end
		wipe();
		en = 1'b0;
		err(3'h2, 4'h4);
		chk(st, 32'h0);
		en = 1'b1;
		err(3'h0, 4'h1);
		err(3'h2, 4'h4);
		chk(st, 32'h0017_0005);
		chk({mcode, 11'h000, raise, notice, lcls}, 32'hA5A5_0012);
		wipe();
		err(3'h1, 4'h1);
		err(3'h2, 4'h4);
		chk(st, 32'h0017_0002);
		wipe();
		exc = 1'b1;
		err(3'h3, 4'h2);
		chk({30'h0, gate, trap}, 32'h3);
		err(3'h0, 4'h4);
		chk(st, 32'h0016_0003);
		err(3'h6, 4'h5);
		chk(st & 32'h001C_FFFF, 32'h001C_0006);
		wipe();
		exc = 1'b0;
		err(3'h3, 4'h2);
		chk(st, 32'h0010_0003);
		chk({mcode, 11'h000, raise, notice, lcls}, 32'hA5A5_000B);
		wipe();
		cap = 1'b0;
		err(3'h2, 4'h4);
		chk(st & 32'h001C_FFFF, 32'h0018_0005);
		wrap_up();
	end
	// whole run needs well under a microsecond of traffic
	initial begin
		#5000;
		n_errors++;
		wrap_up();
	end
endmodule
